/* File: core/query_pkg.sv */
package query_pkg;
  localparam logic [7:0] cmd_query = 8'h98;
  localparam logic [7:0] cmd_reset = 8'hf0;
  localparam logic [7:0] addr_entry_word = 8'h55;
  localparam logic [7:0] addr_entry_byte = 8'haa;
  localparam logic [7:0] addr_table_lo = 8'h10;
  localparam logic [7:0] addr_table_hi = 8'h42;
  localparam logic [7:0] undef_value = 8'h00;
  localparam logic [7:0] region2_big = 8'h3d;
  localparam logic [7:0] region2_small = 8'h1d;
  typedef enum logic [1:0] {
    mode_array,
    mode_autosel,
    mode_query
  } mode_e;
endpackage

/* File: core/query_bus_if.sv */
`timescale 1ns/1ps
interface query_bus_if;
  logic [7:0] addr;
  logic big_density;
  logic [7:0] value;
  logic hit;
  modport ctrl (output addr, output big_density, input value, input hit);
  modport rom (input addr, input big_density, output value, output hit);
endinterface

/* File: core/query_rom.sv */
`timescale 1ns/1ps
module query_rom (
  query_bus_if.rom bus
);
  logic [7:0] v;
  logic h;
  assign bus.value = v;
  assign bus.hit = h;
  always_comb begin
    h = 1'b1;
    unique case (bus.addr)
      8'h10: v = 8'h51;
      8'h11: v = 8'h52;
      8'h12: v = 8'h59;
      8'h13: v = 8'h02;
      8'h15: v = 8'h40;
      8'h1b: v = 8'h23;
      8'h1c: v = 8'h27;
      8'h1f: v = 8'h04;
      8'h21: v = 8'h09;
      8'h23: v = 8'h05;
      8'h25: v = 8'h07;
      8'h27: v = 8'h16;
      8'h28: v = 8'h05;
      8'h2c: v = 8'h03;
      8'h2d, 8'h35: v = 8'h07;
      8'h2f, 8'h37: v = 8'h20;
      8'h31: v = bus.big_density ? query_pkg::region2_big
                                 : query_pkg::region2_small;
      8'h34: v = 8'h01;
      8'h40: v = 8'h50;
      8'h41: v = 8'h52;
      8'h42: v = 8'h49;
      // zero entries
      8'h14, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1d, 8'h1e,
      8'h20, 8'h22, 8'h24, 8'h26, 8'h29, 8'h2a, 8'h2b, 8'h2e,
      8'h30, 8'h32, 8'h33, 8'h36, 8'h38, 8'h39, 8'h3a, 8'h3b,
      8'h3c: v = 8'h00;
      default: begin
        v = query_pkg::undef_value;
        h = 1'b0;
      end
    endcase
  end
endmodule

/* File: core/flash_query_table_mode.sv */
`timescale 1ns/1ps
// Summary of operation
// - word width: writing 98h to address 55h enters query mode.
// - byte width: the entry command is taken at address aah instead.
// - entry accepted whenever idle in array read.
// - reset command leaves query mode, back to the mode it was entered from.
// - entry command also accepted from autoselect mode.
// - reset after entry from autoselect returns to autoselect.
// - 10h-12h read 51h 52h 59h, the ascii id string.
// - 13h,14h read 02h then 00h, command set code.
// - 15h,16h read 40h,00h, extended table pointer.
// - 17h through 1ah read zero.
// - 1bh,1ch read 23h,27h supply limits.
// - 1dh,1eh read zero, no programming-voltage pin.
// - typical timeouts: 1fh=04h, 21h=09h, 20h and 22h zero.
// - max timeout multipliers: 23h=05h, 25h=07h, 24h and 26h zero.
// - 27h reads 16h, device size.
// - 28h,29h read 05h,00h, interface code.
// - 2ah,2bh read zero, no buffered programming.
// - 2ch reads 03h, number of erase regions.
// - 2dh-30h read 07h 00h 20h 00h.
// - 31h reads 3dh or 1dh by density; 32h-34h 00h 00h 01h.
// - 35h-38h read 07h 00h 20h 00h.
// - 39h-3ch read zero.
// - 40h-42h read 50h 52h 49h.
module flash_query_table_mode #(
  parameter int DATA_W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic byte_mode,
  input wire logic big_density,
  input wire logic busy,
  input wire logic autosel_enter,
  input wire logic [DATA_W-1:0] array_data,
  input wire logic [DATA_W-1:0] autosel_data,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic query_active,
  output logic autosel_active
);
  query_pkg::mode_e mode_r, mode_nxt, ret_r, ret_nxt;
  logic [DATA_W-1:0] rd_data_nxt;
  query_bus_if tbl ();

  assign tbl.addr = addr;
  assign tbl.big_density = big_density;

  wire logic [7:0] entry_addr = byte_mode ? query_pkg::addr_entry_byte
                                          : query_pkg::addr_entry_word;
  wire logic is_entry = wr_stb && wr_data == query_pkg::cmd_query &&
                        addr == entry_addr;
  wire logic is_reset = wr_stb && wr_data == query_pkg::cmd_reset;
  // entry refused while an embedded operation keeps the array busy
  wire logic can_enter = !busy && mode_r != query_pkg::mode_query;
  // range guard keeps a stray decode outside the table from leaking out
  wire logic tbl_hit = tbl.hit && addr >= query_pkg::addr_table_lo &&
                       addr <= query_pkg::addr_table_hi;
  wire logic [7:0] tbl_byte = tbl_hit ? tbl.value
                                      : query_pkg::undef_value;

  query_rom rom (
    .bus(tbl)
  );

  always_comb begin
    mode_nxt = mode_r;
    ret_nxt = ret_r;
    unique case (mode_r)
      query_pkg::mode_array: begin
        if (is_entry && can_enter) begin
          mode_nxt = query_pkg::mode_query;
          ret_nxt = query_pkg::mode_array;
        end else if (autosel_enter) begin
          mode_nxt = query_pkg::mode_autosel;
        end
      end
      query_pkg::mode_autosel: begin
        if (is_entry && can_enter) begin
          mode_nxt = query_pkg::mode_query;
          ret_nxt = query_pkg::mode_autosel;
        end else if (is_reset) begin
          mode_nxt = query_pkg::mode_array;
        end
      end
      query_pkg::mode_query: begin
        if (is_reset) begin
          mode_nxt = ret_r;
        end
      end
      default: mode_nxt = query_pkg::mode_array;
    endcase
  end

  always_comb begin
    rd_data_nxt = '0;
    unique case (mode_r)
      // upper lines held low for every width
      query_pkg::mode_query:
        rd_data_nxt[7:0] = tbl_byte;
      query_pkg::mode_autosel: rd_data_nxt = autosel_data;
      default: rd_data_nxt = array_data;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= query_pkg::mode_array;
      ret_r <= query_pkg::mode_array;
    end else begin
      mode_r <= mode_nxt;
      ret_r <= ret_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
      query_active <= 1'b0;
      autosel_active <= 1'b0;
    end else begin
      rd_data <= rd_stb ? rd_data_nxt : '0;
      rd_valid <= rd_stb;
      query_active <= mode_nxt == query_pkg::mode_query;
      autosel_active <= mode_nxt == query_pkg::mode_autosel;
    end
  end
endmodule

/* File: bench/flash_query_monitor.sv */
`timescale 1ns/1ps
module flash_query_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic byte_mode,
  input wire logic busy,
  input wire logic [31:0] rd_data,
  input wire logic rd_valid,
  input wire logic query_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire q = wr_stb && wr_data == 8'h98 && !busy;
  wire r = rd_stb && query_active;
  property p_w; q && !byte_mode && addr == 8'h55 |=> query_active; endproperty
  a_w: assert property (p_w) else $error("word entry missed");
  property p_b; q && byte_mode && addr == 8'haa |=> query_active; endproperty
  a_b: assert property (p_b) else $error("byte entry missed");
  property p_n;
    wr_stb && byte_mode && addr == 8'h55 && !query_active |=> !query_active;
  endproperty
  a_n: assert property (p_n) else $error("byte entry at 55");
  property p_z; wr_stb && busy && !query_active |=> !query_active; endproperty
  a_z: assert property (p_z) else $error("entry while busy");
  property p_x; wr_stb && wr_data == 8'hf0 |=> !query_active; endproperty
  a_x: assert property (p_x) else $error("exit missed");
  property p_i; r && addr == 8'h10 |=> rd_valid && rd_data == 32'h51; endproperty
  a_i: assert property (p_i) else $error("id byte wrong");
  property p_u; rd_valid && $past(query_active) |-> rd_data[31:8] == 0;
  endproperty
  a_u: assert property (p_u) else $error("upper lines set");
  property p_d; r && addr == 8'h43 |=> rd_data == 32'h0; endproperty
  a_d: assert property (p_d) else $error("undefined not zero");
endmodule
bind flash_query_table_mode flash_query_monitor mon (
  .clk(clk),
  .rst(rst),
  .wr_stb(wr_stb),
  .rd_stb(rd_stb),
  .addr(addr),
  .wr_data(wr_data),
  .byte_mode(byte_mode),
  .busy(busy),
  .rd_data(rd_data),
  .rd_valid(rd_valid),
  .query_active(query_active)
);

/* File: bench/host_model.sv */
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] addr,
  output logic [7:0] wr_data
);
  initial {wr_stb, rd_stb, addr, wr_data} = 18'h0;
  // idle bus shows the inverse so a stale value never passes
  task automatic op(input logic w, input logic [7:0] a, d);
    @(negedge clk);
    {wr_stb, rd_stb, addr, wr_data} = {w, !w, a, d};
    @(negedge clk);
    {wr_stb, rd_stb, addr, wr_data} = {2'b0, ~a, ~d};
  endtask
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk, rst, wr_stb, rd_stb, byte_mode, big_density, busy;
  logic autosel_enter, rd_valid, query_active, autosel_active;
  logic [7:0] addr, wr_data;
  logic [31:0] rd_data, array_data, autosel_data;
  int bad_count, n_tests;
  flash_query_table_mode DUT (.*);
  host_model hm (.*);
  task automatic chk(input string n, input logic [31:0] e, s);
    n_tests++;
    if (e !== s) begin
      bad_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rq(input logic [7:0] a, input logic [31:0] e);
    hm.op(1'b0, a, 8'h00);
    chk("rd_valid", 1, rd_valid);
    chk("rd_data", e, rd_data);
  endtask
  task automatic rt(input logic [15:0] ent);
    rq(ent[15:8], {24'h0, ent[7:0]});
  endtask
  task automatic conclude;
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic s_word;
    logic [15:0] t_id[11] = '{16'h1051, 16'h1152, 16'h1259, 16'h1302,
      16'h1400, 16'h1540, 16'h1600, 16'h1700, 16'h1800, 16'h1900,
      16'h1a00};
    logic [15:0] t_sys[12] = '{16'h1b23, 16'h1c27, 16'h1d00, 16'h1e00,
      16'h1f04, 16'h2000, 16'h2109, 16'h2200, 16'h2305, 16'h2400,
      16'h2507, 16'h2600};
    logic [15:0] t_geo[14] = '{16'h2716, 16'h2805, 16'h2900, 16'h2a00,
      16'h2b00, 16'h2c03, 16'h2d07, 16'h2e00, 16'h2f20, 16'h3000,
      16'h3401, 16'h3720, 16'h3900, 16'h3c00};
    logic [15:0] t_ext[4] = '{16'h4050, 16'h4152, 16'h4249, 16'h4300};
    hm.op(1, 8'h55, 8'h98);
    chk("query_active", 1, query_active);
    foreach (t_id[i]) rt(t_id[i]);
    foreach (t_sys[i]) rt(t_sys[i]);
    foreach (t_geo[i]) rt(t_geo[i]);
    foreach (t_ext[i]) rt(t_ext[i]);
    rq(8'h31, 32'h3d);
    hm.op(1, 8'h00, 8'hf0);
    chk("query_active", 0, query_active);
    rq(8'h10, array_data);
  endtask
  task automatic s_byte;
    byte_mode = 1;
    big_density = 0;
    hm.op(1, 8'h55, 8'h98);
    chk("query_active", 0, query_active);
    hm.op(1, 8'haa, 8'h98);
    chk("query_active", 1, query_active);
    rq(8'h31, 32'h1d);
    hm.op(1, 8'h00, 8'hf0);
    byte_mode = 0;
    busy = 1;
    hm.op(1, 8'h55, 8'h98);
    chk("query_active", 0, query_active);
    busy = 0;
  endtask
  task automatic s_auto;
    autosel_enter = 1;
    @(negedge clk) autosel_enter = 0;
    hm.op(1, 8'h55, 8'h98);
    chk("query_active", 1, query_active);
    rq(8'h12, 32'h59);
    hm.op(1, 8'h00, 8'hf0);
    chk("autosel_active", 1, autosel_active);
    rq(8'h10, autosel_data);
    hm.op(1, 8'h00, 8'hf0);
    chk("autosel_active", 0, autosel_active);
    rq(8'h10, array_data);
  endtask
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rst, byte_mode, busy, autosel_enter, big_density} = 5'h11;
    {array_data, autosel_data} = {32'ha5c3_1e69, 32'h5a3c_e196};
    repeat (2) @(negedge clk);
    rst = 0;
    s_word();
    s_byte();
    s_auto();
    conclude();
  end
  initial begin
    #20us;
    bad_count++;
    conclude();
  end
endmodule
